/* fups_pkg.sv */
// Constants, encodings and state codes for the flash user-program sequencer host
package fups_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_MIN_MS = 10;
  // Least time, so round up to whole cycles
  localparam int ERASE_MIN_CYCLES = (ERASE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOP_MIN_CYCLES = 1;
  localparam int TMR_W = 21;

  // ----------------------------------------------------------------
  // Flash organisation
  // ----------------------------------------------------------------
  localparam int SECTOR_COUNT = 384;
  localparam int SECTOR_BYTES = 128;
  localparam int SECTOR_SHIFT = 7;

  // ----------------------------------------------------------------
  // Device register addresses and values
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_SECTOR_HIGH_ADDR = 8'hf6;
  localparam logic [7:0] DEV_SECTOR_LOW_ADDR = 8'hf7;
  localparam logic [7:0] DEV_UNLOCK_KEY_ADDR = 8'hf8;
  localparam logic [7:0] DEV_OP_CONTROL_ADDR_DFLT = 8'hf9;
  localparam logic [7:0] DEV_IRQ_MASK_ADDR_DFLT = 8'hfb;
  localparam logic [7:0] UNLOCK_KEY_ON = 8'ha5;
  localparam logic [7:0] UNLOCK_KEY_OFF = 8'h00;
  localparam logic [7:0] IRQ_MASK_ALL_OFF = 8'h00;
  localparam logic [3:0] MODE_PROGRAM = 4'h5;
  localparam logic [3:0] MODE_ERASE = 4'ha;
  localparam logic [3:0] MODE_HARD_LOCK = 4'h6;
  localparam logic [7:0] ERASE_FAIL_MASK = 8'h08;
  localparam logic [3:0] START_NIBBLE = 4'h1;

  // ----------------------------------------------------------------
  // Host register map (3-bit offsets)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR_LO = 3'h1;
  localparam logic [2:0] REG_ADDR_HI = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_READ_DATA = 3'h5;
  localparam int CMD_IRQ_ABORT_BIT = 2;
  localparam int CMD_GO_BIT = 7;
  localparam logic [1:0] OP_ERASE = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_HARD_LOCK = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [13:0] {
    ST_IDLE       = 14'h0001,
    ST_MASK       = 14'h0002,
    ST_KEY_ON     = 14'h0004,
    ST_SEC_HI     = 14'h0008,
    ST_SEC_LO     = 14'h0010,
    ST_CTRL       = 14'h0020,
    ST_STORE      = 14'h0040,
    ST_NOP_WAIT   = 14'h0080,
    ST_KEY_OFF    = 14'h0100,
    ST_ERASE_WAIT = 14'h0200,
    ST_STAT_RD    = 14'h0400,
    ST_LOAD       = 14'h0800,
    ST_RD_WAIT    = 14'h1000,
    ST_CAPTURE    = 14'h2000
  } fups_state_t;

  // Control byte: mode in the upper nibble, start bit set
  function automatic logic [7:0] fups_ctrl_byte(input logic [3:0] mode);
    fups_ctrl_byte = {mode, START_NIBBLE};
  endfunction : fups_ctrl_byte

  function automatic logic [3:0] fups_op_mode(input logic [1:0] op);
    case (op)
      OP_ERASE: fups_op_mode = MODE_ERASE;
      OP_PROGRAM: fups_op_mode = MODE_PROGRAM;
      default: fups_op_mode = MODE_HARD_LOCK;
    endcase
  endfunction : fups_op_mode

endpackage : fups_pkg

/* fups_timer.sv */
// Down-counting wait timer for the sequencer
`timescale 1ns/1ps
module fups_timer #(
  parameter int W = 21
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Load and status
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic expired
);

  typedef struct packed {
    logic [W-1:0] count;
  } fups_tmr_t;

  fups_tmr_t q, d;

  // Count down to zero and hold there
  always_comb begin
    d = q;
    if (load) begin
      d.count = load_val;
    end else if (q.count != '0) begin
      d.count = q.count - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = (q.count == '0);

endmodule : fups_timer

/* fups_host.sv */
// Host sequencer that drives the flash user-program unit through its registers
`timescale 1ns/1ps
// How it works
// - Software erases a sector before programming bytes into it.
// - After erase start, wait at least 10 ms before touching the sector.
// - Erase start writes 0xa1 to the control register after key and sector.
// - Unlock key 0xa5 is written before any erase, program or lock.
// - Key register is written to zero after each such operation.
// - Erase result is read from control bit 3; a failure is retried.
// - Without abort permission, interrupt mask is cleared before erasing.
// - Sector registers get the destination byte's sector base before programming.
// - Program arming writes 0x51 to the control register before the store.
// - Byte store carries a 16-bit address and one data byte.
// - Hard lock sequence: key on, write 0x61, key off.
// - At least one idle cycle between trigger and key-off write.
module fups_host
  import fups_pkg::*;
#(
  parameter int ERASE_WAIT_CYCLES = fups_pkg::ERASE_MIN_CYCLES,
  parameter int NOP_CYCLES = fups_pkg::NOP_MIN_CYCLES,
  parameter logic [3:0] MAX_RETRIES = 4'h3,
  parameter logic [7:0] DEV_OP_CONTROL_ADDR = fups_pkg::DEV_OP_CONTROL_ADDR_DFLT,
  parameter logic [7:0] DEV_IRQ_MASK_ADDR = fups_pkg::DEV_IRQ_MASK_ADDR_DFLT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Software register port
  input wire logic [2:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Device register access
  output logic [7:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [7:0] dev_rdata,
  // Program-memory load and store
  output logic [15:0] pm_addr,
  output logic [7:0] pm_wdata,
  output logic pm_store,
  output logic pm_load,
  input wire logic [7:0] pm_rdata,
  // Status
  output logic busy
);

  typedef struct packed {
    fups_state_t state;
    logic [1:0] op;
    logic irq_abort;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] read_data;
    logic done;
    logic fail;
    logic locked;
    logic [3:0] retries;
    logic [7:0] sw_rdata;
    logic [7:0] dev_addr;
    logic [7:0] dev_wdata;
    logic dev_wr;
    logic dev_rd;
    logic [15:0] pm_addr;
    logic [7:0] pm_wdata;
    logic pm_store;
    logic pm_load;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic busy;
  } fups_regs_t;

  fups_regs_t q, d;
  logic tmr_expired;
  logic wait_over;

  // ----------------------------------------------------------------
  // Wait timer, shared by the trigger gap and the erase wait
  // ----------------------------------------------------------------
  fups_timer #(
    .W(TMR_W)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .load(q.tmr_load),
    .load_val(q.tmr_val),
    .expired(tmr_expired)
  );

  // Load pulse still pending means the count has not started yet
  assign wait_over = tmr_expired && !q.tmr_load;

  // ----------------------------------------------------------------
  // Sequencer and software registers
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.dev_wr = 1'b0;
    d.dev_rd = 1'b0;
    d.pm_store = 1'b0;
    d.pm_load = 1'b0;
    d.tmr_load = 1'b0;
    d.sw_rdata = 8'h00;
    // Software reads, answered in the next cycle only
    if (sw_rd) begin
      case (sw_addr)
        REG_CMD: d.sw_rdata = {5'h00, q.irq_abort, q.op};
        REG_ADDR_LO: d.sw_rdata = q.addr[7:0];
        REG_ADDR_HI: d.sw_rdata = q.addr[15:8];
        REG_DATA: d.sw_rdata = q.data;
        REG_STATUS: d.sw_rdata = {q.retries, q.locked, q.fail, q.done, q.state != ST_IDLE};
        REG_READ_DATA: d.sw_rdata = q.read_data;
        default: d.sw_rdata = 8'h00;
      endcase
    end
    case (q.state)
      ST_IDLE: begin
        // Setup writes are taken only while idle so a running sequence stays stable
        if (sw_wr) begin
          case (sw_addr)
            REG_ADDR_LO: d.addr[7:0] = sw_wdata;
            REG_ADDR_HI: d.addr[15:8] = sw_wdata;
            REG_DATA: d.data = sw_wdata;
            REG_CMD: begin
              d.op = sw_wdata[1:0];
              d.irq_abort = sw_wdata[CMD_IRQ_ABORT_BIT];
              if (sw_wdata[CMD_GO_BIT]) begin
                d.done = 1'b0;
                d.fail = 1'b0;
                d.retries = 4'h0;
                case (sw_wdata[1:0])
                  OP_READ: d.state = ST_LOAD;
                  OP_ERASE: d.state = sw_wdata[CMD_IRQ_ABORT_BIT] ? ST_KEY_ON : ST_MASK;
                  default: d.state = ST_KEY_ON;
                endcase
              end
            end
            default: d = d;
          endcase
        end
      end
      ST_MASK: begin
        // Keep interrupts from cutting the erase short
        d.dev_wr = 1'b1;
        d.dev_addr = DEV_IRQ_MASK_ADDR;
        d.dev_wdata = IRQ_MASK_ALL_OFF;
        d.state = ST_KEY_ON;
      end
      ST_KEY_ON: begin
        d.dev_wr = 1'b1;
        d.dev_addr = DEV_UNLOCK_KEY_ADDR;
        d.dev_wdata = UNLOCK_KEY_ON;
        d.state = (q.op == OP_HARD_LOCK) ? ST_CTRL : ST_SEC_HI;
      end
      ST_SEC_HI: begin
        d.dev_wr = 1'b1;
        d.dev_addr = DEV_SECTOR_HIGH_ADDR;
        d.dev_wdata = q.addr[15:8];
        d.state = ST_SEC_LO;
      end
      ST_SEC_LO: begin
        // Low seven bits are don't-care, sent as zero
        d.dev_wr = 1'b1;
        d.dev_addr = DEV_SECTOR_LOW_ADDR;
        d.dev_wdata = {q.addr[SECTOR_SHIFT], 7'h00};
        d.state = ST_CTRL;
      end
      ST_CTRL: begin
        d.dev_wr = 1'b1;
        d.dev_addr = DEV_OP_CONTROL_ADDR;
        d.dev_wdata = fups_ctrl_byte(fups_op_mode(q.op));
        if (q.op == OP_PROGRAM) begin
          d.state = ST_STORE;
        end else begin
          d.tmr_load = 1'b1;
          d.tmr_val = TMR_W'(NOP_CYCLES);
          d.state = ST_NOP_WAIT;
        end
      end
      ST_STORE: begin
        // One byte per store, no bursts
        d.pm_store = 1'b1;
        d.pm_addr = q.addr;
        // Store can only clear bits, so the caller erases the sector first
        d.pm_wdata = q.data;
        d.tmr_load = 1'b1;
        d.tmr_val = TMR_W'(NOP_CYCLES);
        d.state = ST_NOP_WAIT;
      end
      ST_NOP_WAIT: begin
        if (wait_over) begin
          d.state = ST_KEY_OFF;
        end
      end
      ST_KEY_OFF: begin
        d.dev_wr = 1'b1;
        d.dev_addr = DEV_UNLOCK_KEY_ADDR;
        d.dev_wdata = UNLOCK_KEY_OFF;
        if (q.op == OP_ERASE) begin
          d.tmr_load = 1'b1;
          d.tmr_val = TMR_W'(ERASE_WAIT_CYCLES);
          d.state = ST_ERASE_WAIT;
        end else begin
          // Device rejects silently when locked, so the host only records the attempt
          d.locked = q.locked | (q.op == OP_HARD_LOCK);
          d.done = 1'b1;
          d.state = ST_IDLE;
        end
      end
      ST_ERASE_WAIT: begin
        if (wait_over) begin
          d.state = ST_STAT_RD;
        end
      end
      ST_STAT_RD: begin
        d.dev_rd = 1'b1;
        d.dev_addr = DEV_OP_CONTROL_ADDR;
        d.state = ST_RD_WAIT;
      end
      ST_LOAD: begin
        d.pm_load = 1'b1;
        d.pm_addr = q.addr;
        d.state = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        d.state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        if (q.op == OP_READ) begin
          d.read_data = pm_rdata;
          d.done = 1'b1;
          d.state = ST_IDLE;
        end else if (((dev_rdata & ERASE_FAIL_MASK) != 8'h00) && (q.retries < MAX_RETRIES)) begin
          d.retries = q.retries + 4'h1;
          d.state = ST_KEY_ON;
        end else begin
          d.fail = (dev_rdata & ERASE_FAIL_MASK) != 8'h00;
          d.done = 1'b1;
          d.state = ST_IDLE;
        end
      end
      default: d.state = ST_IDLE;
    endcase
    // Busy kept in a flop so the pin never glitches on state decode
    d.busy = (d.state != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.state <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign sw_rdata = q.sw_rdata;
  assign dev_addr = q.dev_addr;
  assign dev_wdata = q.dev_wdata;
  assign dev_wr = q.dev_wr;
  assign dev_rd = q.dev_rd;
  assign pm_addr = q.pm_addr;
  assign pm_wdata = q.pm_wdata;
  assign pm_store = q.pm_store;
  assign pm_load = q.pm_load;
  assign busy = q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic key_on_h;
  logic mask_off_h;
  logic [TMR_W-1:0] since_erase_h;
  logic ctrl_wr;
  assign ctrl_wr = dev_wr && (dev_addr == DEV_OP_CONTROL_ADDR);

  // Track what the device has been told, from the pins plus q.state and q.op
  always_ff @(posedge clk) begin
    if (reset) begin
      key_on_h <= 1'b0;
      mask_off_h <= 1'b0;
      since_erase_h <= '0;
    end else begin
      if (dev_wr && dev_addr == DEV_UNLOCK_KEY_ADDR) begin
        key_on_h <= (dev_wdata == UNLOCK_KEY_ON);
      end
      if (q.state == ST_IDLE) begin
        mask_off_h <= 1'b0;
      end else if (dev_wr && dev_addr == DEV_IRQ_MASK_ADDR && dev_wdata == IRQ_MASK_ALL_OFF) begin
        mask_off_h <= 1'b1;
      end
      if (ctrl_wr && q.op == OP_ERASE) begin
        since_erase_h <= '0;
      end else if (since_erase_h != '1) begin
        since_erase_h <= since_erase_h + TMR_W'(1);
      end
    end
  end

  a_ctrl_needs_key: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr |-> key_on_h) else $error("control written without unlock key");
  a_store_needs_key: assert property (@(posedge clk) disable iff (reset)
    pm_store |-> key_on_h && $past(ctrl_wr)) else $error("store without unlock or arm");
  a_key_off_after: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr |-> ##[2:40] (dev_wr && dev_addr == DEV_UNLOCK_KEY_ADDR && dev_wdata == UNLOCK_KEY_OFF))
    else $error("unlock key not cleared after trigger");
  a_nop_gap: assert property (@(posedge clk) disable iff (reset)
    (dev_wr && dev_addr == DEV_UNLOCK_KEY_ADDR && dev_wdata == UNLOCK_KEY_OFF)
    |-> !$past(ctrl_wr) && !$past(pm_store)) else $error("no gap before key clear");
  a_ctrl_value: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr |-> dev_wdata == ((q.op == OP_ERASE) ? 8'ha1 : (q.op == OP_PROGRAM) ? 8'h51 : 8'h61))
    else $error("wrong control byte");
  a_sector_base: assert property (@(posedge clk) disable iff (reset)
    (dev_wr && dev_addr == DEV_SECTOR_LOW_ADDR) |-> dev_wdata == {q.addr[7], 7'h00}
    && $past(dev_wr) && $past(dev_wdata) == q.addr[15:8]) else $error("wrong sector base");
  a_store_addr: assert property (@(posedge clk) disable iff (reset)
    pm_store |-> pm_addr == q.addr && pm_wdata == q.data) else $error("wrong store target");
  a_erase_wait: assert property (@(posedge clk) disable iff (reset)
    (dev_rd && q.op == OP_ERASE) |-> since_erase_h >= TMR_W'(ERASE_WAIT_CYCLES))
    else $error("erase sector touched too early");
  a_retry_on_fail: assert property (@(posedge clk) disable iff (reset)
    (q.state == ST_CAPTURE && q.op == OP_ERASE && dev_rdata[3] && q.retries < MAX_RETRIES)
    |=> ##1 (dev_wr && dev_wdata == UNLOCK_KEY_ON)) else $error("failed erase not retried");
  a_mask_cleared: assert property (@(posedge clk) disable iff (reset)
    (ctrl_wr && q.op == OP_ERASE && !q.irq_abort) |-> mask_off_h)
    else $error("erase started with interrupts unmasked");

  c_erase_done: cover property (@(posedge clk) disable iff (reset)
    q.state == ST_CAPTURE && q.op == OP_ERASE && !dev_rdata[3]);
  c_erase_retry: cover property (@(posedge clk) disable iff (reset)
    q.state == ST_CAPTURE && q.op == OP_ERASE && dev_rdata[3]);
  c_program: cover property (@(posedge clk) disable iff (reset) pm_store);
  c_hard_lock: cover property (@(posedge clk) disable iff (reset)
    ctrl_wr && q.op == OP_HARD_LOCK);
  c_read: cover property (@(posedge clk) disable iff (reset)
    q.state == ST_CAPTURE && q.op == OP_READ);

endmodule : fups_host

/* fups_dev_model.sv */
// Behavioural model of the flash unit that the sequencer host drives
`timescale 1ns/1ps
module fups_dev_model #(
  parameter logic [7:0] CTRL_ADDR = 8'hf9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [7:0] dev_rdata,
  // Program-memory load and store
  input wire logic [15:0] pm_addr,
  input wire logic [7:0] pm_wdata,
  input wire logic pm_store,
  input wire logic pm_load,
  output logic [7:0] pm_rdata,
  // Interrupt that breaks an erase
  input wire logic irq_abort
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [0:49151];
  logic [7:0] key_q, sec_hi_q, sec_lo_q, ctrl_q;
  logic fail_q, locked_q, armed_q;
  logic [15:0] base;
  int bad;
  int since_trig;

  // Sector base from the register pair, low bits ignored
  assign base = {sec_hi_q, sec_lo_q[7], 7'h00};

  // Lock survives reset, so it is only cleared at power-up
  initial begin
    locked_q = 1'b0;
    bad = 0;
    dev_rdata = 8'h00;
    pm_rdata = 8'h00;
    for (int i = 0; i < 49152; i++) mem[i] = 8'hff;
  end

  // ----------------------------------------------------------------
  // Register and flash behaviour
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    since_trig <= since_trig + 1;
    if (reset) begin
      key_q <= 8'h00;
      sec_hi_q <= 8'h00;
      sec_lo_q <= 8'h00;
      ctrl_q <= 8'h00;
      fail_q <= 1'b0;
      armed_q <= 1'b0;
      since_trig <= 100;
    end else begin
      if (dev_wr && dev_addr == 8'hf8) begin
        if (dev_wdata != 8'ha5 && since_trig < 2) bad++;
        key_q <= dev_wdata;
      end
      if (dev_wr && dev_addr == 8'hf6) sec_hi_q <= dev_wdata;
      if (dev_wr && dev_addr == 8'hf7) sec_lo_q <= dev_wdata;
      if (dev_wr && dev_addr == CTRL_ADDR) begin
        ctrl_q <= {dev_wdata[7:4], 4'h0};
        armed_q <= 1'b0;
        since_trig <= 0;
        if (key_q != 8'ha5) begin
          bad++;
        end else if (dev_wdata == 8'ha1) begin
          // A rejected erase under lock leaves no trace in the status bit
          fail_q <= irq_abort && !locked_q;
          if (!irq_abort && !locked_q) for (int i = 0; i < 128; i++) mem[base + i] = 8'hff;
        end else if (dev_wdata == 8'h51) begin
          armed_q <= 1'b1;
        end else if (dev_wdata[7:4] == 4'h6) begin
          locked_q <= 1'b1;
        end
      end
      // One byte per arming, only inside the loaded sector
      if (pm_store) begin
        if (!armed_q || pm_addr[15:7] != base[15:7] || key_q != 8'ha5) bad++;
        else if (!locked_q) mem[pm_addr] = mem[pm_addr] & pm_wdata;
        armed_q <= 1'b0;
      end
      // Data stand one cycle, then scramble so stale values never match
      dev_rdata <= dev_rd ? {ctrl_q[7:4], fail_q, 3'h0} : ~dev_rdata;
      pm_rdata <= pm_load ? mem[pm_addr] : ~pm_rdata;
    end
  end
endmodule : fups_dev_model

/* testbench.sv */
// Self-checking testbench for the flash user-program sequencer host
`timescale 1ns/1ps
module testbench;
  import fups_pkg::*;
  localparam int EW = 50;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic irq_abort = 1'b0;
  logic [7:0] sw_rdata, dev_addr, dev_wdata, dev_rdata, pm_wdata, pm_rdata;
  logic dev_wr, dev_rd, pm_store, pm_load, busy;
  logic [15:0] pm_addr;
  int mismatches = 0;
  int check_count = 0;
  int seed = 57;
  int mask_writes = 0;
  logic [7:0] exp_mem [int];
  logic locked = 1'b0;

  // ----------------------------------------------------------------
  // Clock, instances, monitors
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  fups_host #(.ERASE_WAIT_CYCLES(EW)) dut (.clk(clk), .reset(reset), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_store(pm_store),
    .pm_load(pm_load), .pm_rdata(pm_rdata), .busy(busy));

  fups_dev_model u_dev (.clk(clk), .reset(reset), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_store(pm_store), .pm_load(pm_load),
    .pm_rdata(pm_rdata), .irq_abort(irq_abort));

  // Count mask clears so the abort option can be seen at the wire
  always @(posedge clk) begin
    if (dev_wr === 1'b1 && dev_addr === DEV_IRQ_MASK_ADDR_DFLT) mask_writes++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task sw_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task sw_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read

  // Expected status: retries, lock, fail, done, idle
  function automatic logic [7:0] stat(input logic [3:0] r, input logic f);
    stat = {r, locked, f, 1'b1, 1'b0};
  endfunction : stat

  function automatic logic [7:0] expb(input int a);
    expb = exp_mem.exists(a) ? exp_mem[a] : 8'hff;
  endfunction : expb

  task run(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
           input logic ab, input logic [7:0] exp_st);
    logic [7:0] st;
    int n;
    sw_write(REG_ADDR_LO, a[7:0]);
    sw_write(REG_ADDR_HI, a[15:8]);
    sw_write(REG_DATA, d);
    sw_write(REG_CMD, {1'b1, 4'h0, ab, op});
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (busy !== 1'b0 && n < 2000);
    if (n >= 2000) check("busy_timeout", 16'h1, 16'h0);
    sw_read(REG_STATUS, st);
    check("status", st, exp_st);
    check("key_off", u_dev.key_q, UNLOCK_KEY_OFF);
  endtask : run

  task rd(input logic [15:0] a);
    logic [7:0] v;
    run(OP_READ, a, 8'h00, 1'b0, stat(4'h0, 1'b0));
    sw_read(REG_READ_DATA, v);
    check("flash", v, expb(a));
  endtask : rd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v, d;
    logic [15:0] base, a;
    int m;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    sw_read(REG_STATUS, v);
    check("reset_status", v, 8'h00);
    sw_read(3'h6, v);
    check("unmapped", v, 8'h00);
    for (int k = 0; k < 2; k++) begin
      base = (k == 0) ? 16'(383 * 128) : 16'((($random(seed) & 32'hffff) % 384) * 128);
      m = mask_writes;
      run(OP_ERASE, base + 16'h5, 8'h00, 1'b0, stat(4'h0, 1'b0));
      check("mask_clear", 16'(mask_writes), 16'(m + 1));
      for (int i = 0; i < 128; i++) exp_mem[base + i] = 8'hff;
      a = base + 16'($random(seed) & 32'h7f);
      d = 8'($random(seed));
      rd(a);
      run(OP_PROGRAM, a, d, 1'b0, stat(4'h0, 1'b0));
      exp_mem[a] = d;
      rd(a);
      run(OP_PROGRAM, a, 8'h0f, 1'b0, stat(4'h0, 1'b0));
      exp_mem[a] = d & 8'h0f;
      rd(a);
    end
    // Interrupted erase: retried, then reported as failed
    m = mask_writes;
    irq_abort <= 1'b1;
    run(OP_ERASE, a, 8'h00, 1'b1, stat(4'h3, 1'b1));
    irq_abort <= 1'b0;
    check("abort_no_mask", 16'(mask_writes), 16'(m));
    rd(a);
    // Hard lock, then writes and erases must leave flash alone
    locked = 1'b1;
    run(OP_HARD_LOCK, 16'h0000, 8'h00, 1'b0, stat(4'h0, 1'b0));
    run(OP_ERASE, a, 8'h00, 1'b0, stat(4'h0, 1'b0));
    run(OP_PROGRAM, a, 8'h00, 1'b0, stat(4'h0, 1'b0));
    rd(a);
    check("dev_order", 16'(u_dev.bad), 16'h0);
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule : testbench
